// ==== include/mtc_pkg.sv ====
// Package for the measurement threshold compare block: register map, fields, types.
package mtc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [3:0] MTC_IDX_TEMP_HIGH = 4'h6;
  localparam logic [3:0] MTC_IDX_TEMP_LOW = 4'h7;
  localparam logic [3:0] MTC_IDX_FIRST_AUXILIARY_INPUT_HIGH = 4'h8;
  localparam logic [3:0] MTC_IDX_FIRST_AUXILIARY_INPUT_LOW = 4'h9;
  localparam logic [3:0] MTC_IDX_SECOND_AUXILIARY_INPUT_HIGH = 4'ha;
  localparam logic [3:0] MTC_IDX_SECOND_AUXILIARY_INPUT_LOW = 4'hb;
  localparam logic [3:0] MTC_IDX_CONFIG = 4'hc;

  // ==========================================================
  // Field layout
  localparam int MTC_LIMIT_W = 12;
  localparam int MTC_EN_BIT = 12;
  localparam int MTC_CFG_SCAN_TEMPERATURE_SELECT_BIT = 15;
  localparam int MTC_CFG_PINSEL_BIT = 9;
  localparam int MTC_CFG_FLAG_LSB = 3;
  localparam logic [11:0] MTC_LIMIT_LOW_RST = 12'h000;
  localparam logic [11:0] MTC_LIMIT_HIGH_RST = 12'hfff;

  // AXI responses
  localparam logic [1:0] MTC_RESP_OKAY = 2'b00;
  localparam logic [1:0] MTC_RESP_SLVERR = 2'b10;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    MTC_CH_TEMP_A = 2'b00,
    MTC_CH_TEMP_B = 2'b01,
    MTC_CH_FIRST_AUXILIARY_INPUT = 2'b10,
    MTC_CH_SECOND_AUXILIARY_INPUT = 2'b11
  } mtc_chan_t;

  // One limit register: check enable plus 12-bit value
  typedef struct packed
  {
    logic en;
    logic [11:0] value;
  } mtc_limit_t;

  // Completed conversion from the measurement converter
  typedef struct packed
  {
    logic done;
    mtc_chan_t chan;
    logic [11:0] code;
  } mtc_conv_t;

  // Scan context from the sequencer
  typedef struct packed
  {
    logic auto_scan;
    logic [1:0] mode_select;
  } mtc_scan_t;

  // Flag order: temp high, temp low, first_auxiliary_input high, first_auxiliary_input low, second_auxiliary_input high, second_auxiliary_input low
  typedef logic [5:0] mtc_flags_t;

endpackage

// ==== core/mtc_top.sv ====
// Measurement threshold compare block with an AXI4-Lite register slave.
`timescale 1ns/100ps

module mtc_top
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Converter results and scan context
  input wire mtc_conv_t conv_i,
  input wire mtc_scan_t scan_i,
  // Limit crossing outputs
  output logic irq_o,
  output logic pin_irq_o,
  output mtc_flags_t flags_o,
  // AXI4-Lite write address, data and response
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] word_index(input logic [7:0] addr);
    word_index = addr[5:2];
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    addr_mapped = (addr[7:6] == 2'b00) && (idx >= MTC_IDX_TEMP_HIGH) && (idx <= MTC_IDX_CONFIG);
  endfunction

  // Limit word as seen on the bus; bits 15..13 always zero
  function automatic logic [31:0] limit_word(input mtc_limit_t lim);
    limit_word = 32'h0000_0000;
    limit_word[MTC_EN_BIT] = lim.en;
    limit_word[MTC_LIMIT_W-1:0] = lim.value;
  endfunction

  // Only bits 12..0 are taken; reserved bits are dropped
  function automatic mtc_limit_t limit_write(input mtc_limit_t old, input logic [31:0] data,
                                             input logic [3:0] strb);
    mtc_limit_t res;
    res = old;
    if (strb[0])
    begin
      res.value[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res.value[11:8] = data[11:8];
      res.en = data[MTC_EN_BIT];
    end
    limit_write = res;
  endfunction

  // ==========================================================
  // Register state
  mtc_limit_t temp_high_q, temp_high_d;
  mtc_limit_t temp_low_q, temp_low_d;
  mtc_limit_t first_auxiliary_input_high_q, first_auxiliary_input_high_d;
  mtc_limit_t first_auxiliary_input_low_q, first_auxiliary_input_low_d;
  mtc_limit_t second_auxiliary_input_high_q, second_auxiliary_input_high_d;
  mtc_limit_t second_auxiliary_input_low_q, second_auxiliary_input_low_d;
  logic scan_temp_sel_q, scan_temp_sel_d;
  logic pin_sel_q, pin_sel_d;
  // Compare results, declared here because the config read returns them
  mtc_flags_t flags_q, flags_d;

  // AXI slave state
  logic aw_held_q, aw_held_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  logic do_write;
  logic do_read;
  logic [3:0] wr_idx;

  // Write completes once both halves are held and no response is pending
  always_comb
  begin
    do_write = aw_held_q && w_held_q && !bvalid_q;
    do_read = s_axi_arvalid && !rvalid_q;
    wr_idx = word_index(aw_addr_q);
  end

  always_comb
  begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    temp_high_d = temp_high_q;
    temp_low_d = temp_low_q;
    first_auxiliary_input_high_d = first_auxiliary_input_high_q;
    first_auxiliary_input_low_d = first_auxiliary_input_low_q;
    second_auxiliary_input_high_d = second_auxiliary_input_high_q;
    second_auxiliary_input_low_d = second_auxiliary_input_low_q;
    scan_temp_sel_d = scan_temp_sel_q;
    pin_sel_d = pin_sel_q;
    if (s_axi_awvalid && !aw_held_q)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_mapped(aw_addr_q) ? MTC_RESP_OKAY : MTC_RESP_SLVERR;
      if (addr_mapped(aw_addr_q))
      begin
        case (wr_idx)
          MTC_IDX_TEMP_HIGH: temp_high_d = limit_write(temp_high_q, w_data_q, w_strb_q);
          MTC_IDX_TEMP_LOW: temp_low_d = limit_write(temp_low_q, w_data_q, w_strb_q);
          MTC_IDX_FIRST_AUXILIARY_INPUT_HIGH: first_auxiliary_input_high_d = limit_write(first_auxiliary_input_high_q, w_data_q, w_strb_q);
          MTC_IDX_FIRST_AUXILIARY_INPUT_LOW: first_auxiliary_input_low_d = limit_write(first_auxiliary_input_low_q, w_data_q, w_strb_q);
          MTC_IDX_SECOND_AUXILIARY_INPUT_HIGH: second_auxiliary_input_high_d = limit_write(second_auxiliary_input_high_q, w_data_q, w_strb_q);
          MTC_IDX_SECOND_AUXILIARY_INPUT_LOW: second_auxiliary_input_low_d = limit_write(second_auxiliary_input_low_q, w_data_q, w_strb_q);
          MTC_IDX_CONFIG:
          begin
            if (w_strb_q[1])
            begin
              scan_temp_sel_d = w_data_q[MTC_CFG_SCAN_TEMPERATURE_SELECT_BIT];
              pin_sel_d = w_data_q[MTC_CFG_PINSEL_BIT];
            end
          end
          default: ;
        endcase
      end
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (do_read)
    begin
      rvalid_d = 1'b1;
      rresp_d = addr_mapped(s_axi_araddr) ? MTC_RESP_OKAY : MTC_RESP_SLVERR;
      rdata_d = 32'h0000_0000;
      case (word_index(s_axi_araddr))
        MTC_IDX_TEMP_HIGH: rdata_d = limit_word(temp_high_q);
        MTC_IDX_TEMP_LOW: rdata_d = limit_word(temp_low_q);
        MTC_IDX_FIRST_AUXILIARY_INPUT_HIGH: rdata_d = limit_word(first_auxiliary_input_high_q);
        MTC_IDX_FIRST_AUXILIARY_INPUT_LOW: rdata_d = limit_word(first_auxiliary_input_low_q);
        MTC_IDX_SECOND_AUXILIARY_INPUT_HIGH: rdata_d = limit_word(second_auxiliary_input_high_q);
        MTC_IDX_SECOND_AUXILIARY_INPUT_LOW: rdata_d = limit_word(second_auxiliary_input_low_q);
        MTC_IDX_CONFIG:
        begin
          rdata_d[MTC_CFG_SCAN_TEMPERATURE_SELECT_BIT] = scan_temp_sel_q;
          rdata_d[MTC_CFG_PINSEL_BIT] = pin_sel_q;
          rdata_d[MTC_CFG_FLAG_LSB +: 6] = flags_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
      if (!addr_mapped(s_axi_araddr))
      begin
        rdata_d = 32'h0000_0000;
      end
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= MTC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= MTC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      temp_high_q <= '{en: 1'b0, value: MTC_LIMIT_HIGH_RST};
      temp_low_q <= '{en: 1'b0, value: MTC_LIMIT_LOW_RST};
      first_auxiliary_input_high_q <= '{en: 1'b0, value: MTC_LIMIT_HIGH_RST};
      first_auxiliary_input_low_q <= '{en: 1'b0, value: MTC_LIMIT_LOW_RST};
      second_auxiliary_input_high_q <= '{en: 1'b0, value: MTC_LIMIT_HIGH_RST};
      second_auxiliary_input_low_q <= '{en: 1'b0, value: MTC_LIMIT_LOW_RST};
      scan_temp_sel_q <= 1'b0;
      pin_sel_q <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      temp_high_q <= temp_high_d;
      temp_low_q <= temp_low_d;
      first_auxiliary_input_high_q <= first_auxiliary_input_high_d;
      first_auxiliary_input_low_q <= first_auxiliary_input_low_d;
      second_auxiliary_input_high_q <= second_auxiliary_input_high_d;
      second_auxiliary_input_low_q <= second_auxiliary_input_low_d;
      scan_temp_sel_q <= scan_temp_sel_d;
      pin_sel_q <= pin_sel_d;
    end
  end

  // ==========================================================
  // Threshold compare
  // Flags hold the last result for each limit and only change on a new conversion
  logic irq_q, irq_d;
  logic pin_irq_q, pin_irq_d;
  logic temp_sel;
  logic temp_hit;
  mtc_chan_t temp_chan;

  always_comb
  begin
    temp_chan = scan_temp_sel_q ? MTC_CH_TEMP_B : MTC_CH_TEMP_A;
    if (!scan_i.auto_scan)
    begin
      temp_chan = scan_i.mode_select[0] ? MTC_CH_TEMP_B : MTC_CH_TEMP_A;
    end
    temp_sel = (conv_i.chan == temp_chan);
    temp_hit = conv_i.done && temp_sel;
    flags_d = flags_q;
    if (temp_hit)
    begin
      flags_d[5] = temp_high_q.en && (conv_i.code >= temp_high_q.value);
      flags_d[4] = temp_low_q.en && (conv_i.code <= temp_low_q.value);
    end
    if (conv_i.done && conv_i.chan == MTC_CH_FIRST_AUXILIARY_INPUT)
    begin
      flags_d[3] = first_auxiliary_input_high_q.en && (conv_i.code >= first_auxiliary_input_high_q.value);
      flags_d[2] = first_auxiliary_input_low_q.en && (conv_i.code <= first_auxiliary_input_low_q.value);
    end
    if (conv_i.done && conv_i.chan == MTC_CH_SECOND_AUXILIARY_INPUT)
    begin
      flags_d[1] = second_auxiliary_input_high_q.en && (conv_i.code >= second_auxiliary_input_high_q.value);
      flags_d[0] = second_auxiliary_input_low_q.en && (conv_i.code <= second_auxiliary_input_low_q.value);
    end
    irq_d = |flags_d;
    pin_irq_d = pin_sel_q && (|flags_d);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flags_q <= 6'b00_0000;
      irq_q <= 1'b0;
      pin_irq_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      irq_q <= irq_d;
      pin_irq_q <= pin_irq_d;
    end
  end

  // ==========================================================
  // Outputs
  assign irq_o = irq_q;
  assign pin_irq_o = pin_irq_q;
  assign flags_o = flags_q;
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

// ==== sim/mtc_props.sv ====
// Port-level assertion checker for the threshold compare block.
`timescale 1ns/100ps

module mtc_props
  import mtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Crossing outputs
  input wire logic irq_o,
  input wire logic pin_irq_o,
  input wire mtc_flags_t flags_o,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================
  // Crossing outputs
  AST_IRQ_OR: assert property (irq_o == (|flags_o))
    else $error("irq differs from OR of flags");
  AST_PIN: assert property (pin_irq_o |-> irq_o)
    else $error("pin irq without irq");
  AST_RST: assert property ($rose(rstn_i) |-> flags_o == '0 && !irq_o)
    else $error("flags set after reset");

  // ==========================================
  // Register bus
  AST_BVALID: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RVALID: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_RZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0)
    else $error("upper read bits not zero");
  AST_ARREADY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  AST_AWREADY: assert property ((s_axi_awvalid && s_axi_awready) ||
    (s_axi_wvalid && s_axi_wready) |=> !s_axi_awready || !s_axi_wready)
    else $error("write channel still ready after handshake");
endmodule

bind mtc_top mtc_props i_mtc_props (.*);

// ==== sim/tb.sv ====
// Self-checking bench for the threshold compare block.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end

module tb;
  import mtc_pkg::*;
  logic clk_i, rstn_i, irq_o, pin_irq_o;
  mtc_conv_t conv_i;
  mtc_scan_t scan_i, sc;
  mtc_flags_t flags_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pinsel;
  int error_cnt, checks_done, cyc;

  mtc_top i_mtc_top (.*);

  initial
  begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================
  // Hang guard: the whole run needs well under this
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [7:0] adr(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // ==========================================
  // Bus tasks: each channel released at its own handshake edge
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One conversion, then the flags are read once they have settled
  task cv(input mtc_chan_t c, input logic [11:0] k, input mtc_flags_t e);
    @(posedge clk_i);
    scan_i <= sc;
    conv_i <= {1'b1, c, k};
    @(posedge clk_i);
    conv_i.done <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("flags", e, flags_o)
    `CHK("irq", |e, irq_o)
    `CHK("pin", (|e) & pinsel, pin_irq_o)
  endtask

  initial
  begin
    {rstn_i, conv_i, scan_i, sc, pinsel, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 6; i < 13; i++)
    begin
      rd(adr(i[3:0]));
      `CHK("reset", (i < 12 && !i[0]) ? 32'h0000_0fff : 32'h0000_0000, d)
      `CHK("mapped rresp", MTC_RESP_OKAY, r)
    end
    cv(MTC_CH_TEMP_A, 12'h000, '0);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'h000, '0);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'hfff, '0);
    cv(MTC_CH_SECOND_AUXILIARY_INPUT, 12'hfff, '0);
    cv(MTC_CH_SECOND_AUXILIARY_INPUT, 12'h000, '0);
    for (int i = 6; i < 12; i++)
    begin
      wr(adr(i[3:0]), 32'hffff_ffff);
      rd(adr(i[3:0]));
      `CHK("reserved", 32'h0000_1fff, d)
      wr(adr(i[3:0]), i[0] ? 32'h0000_1100 : 32'h0000_1800);
    end
    cv(MTC_CH_TEMP_A, 12'h800, 6'b10_0000);
    cv(MTC_CH_TEMP_A, 12'h100, 6'b01_0000);
    cv(MTC_CH_TEMP_A, 12'h101, '0);
    cv(MTC_CH_TEMP_B, 12'h900, '0);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'h800, 6'b00_1000);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'h100, 6'b00_0100);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'h7ff, '0);
    cv(MTC_CH_SECOND_AUXILIARY_INPUT, 12'hfff, 6'b00_0010);
    cv(MTC_CH_SECOND_AUXILIARY_INPUT, 12'h000, 6'b00_0001);
    cv(MTC_CH_SECOND_AUXILIARY_INPUT, 12'h101, '0);
    rd(8'h3c);
    `CHK("unmapped rresp", MTC_RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0000_0000, d)
    wr(8'h00, 32'h0000_1fff);
    `CHK("unmapped bresp", MTC_RESP_SLVERR, r)
    sc = 3'b001;
    cv(MTC_CH_TEMP_B, 12'h900, 6'b10_0000);
    sc = 3'b100;
    cv(MTC_CH_TEMP_A, 12'h7ff, '0);
    wr(adr(MTC_IDX_CONFIG), 32'h0000_8200);
    pinsel = 1'b1;
    cv(MTC_CH_TEMP_B, 12'h100, 6'b01_0000);
    rd(adr(MTC_IDX_CONFIG));
    `CHK("config flags", 32'h0000_8280, d)
    wr(adr(MTC_IDX_FIRST_AUXILIARY_INPUT_HIGH), 32'h0000_0800);
    cv(MTC_CH_FIRST_AUXILIARY_INPUT, 12'hfff, 6'b01_0000);
    report_and_stop();
  end
endmodule
